// ---- cpu_bitop_transfer_exec.sv ----
`timescale 1ns/100ps
`include "exec_consts.svh"

module cpu_bitop_transfer_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Operation issue
    input wire logic op_valid,
    output logic op_ready,
    input wire exec_pkg::op_e op_code,
    input wire logic [4:0] op_rd,
    input wire logic [4:0] op_rr,
    input wire logic [2:0] op_bit,
    input wire exec_pkg::addr_mode_e op_mode,
    input wire exec_pkg::ptr_e op_ptr,
    input wire logic [5:0] op_disp,
    input wire logic [15:0] op_addr,
    // Data memory
    output logic [15:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    output logic dmem_we,
    output logic dmem_re,
    input wire logic [7:0] dmem_rdata,
    // Program memory
    output logic [14:0] pmem_addr,
    output logic pmem_re,
    input wire logic [15:0] pmem_rdata,
    // Control pulses
    output logic sleep_req,
    output logic wdt_restart,
    output logic debug_break,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // Status view
    output logic [7:0] status_flags
);
    import exec_pkg::*;

    // Architectural state
    logic [7:0] gpr_reg [0:`GPR_COUNT-1];
    logic [7:0] flags_reg;
    logic [15:0] sp_reg;
    state_e state_reg;
    // Pending load target
    logic [4:0] dst_reg;
    logic load_pend_reg;
    logic byte_sel_reg;
    // Operand views
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [4:0] ptr_idx;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [15:0] eff_addr;
    logic [7:0] ror_val;
    // Decoded classes
    logic accept;
    logic is_ind;
    logic is_pgm;
    logic is_mem_rd;
    logic is_mem_wr;
    logic ptr_upd;
    // Ready only while no access is in flight
    assign op_ready = (state_reg == ST_IDLE);
    assign accept = op_valid && op_ready;
    assign status_flags = flags_reg;
    // Operand fetch
    assign rd_val = gpr_reg[op_rd];
    assign rr_val = gpr_reg[op_rr];
    assign ror_val = {flags_reg[`FLAG_C], rd_val[7:1]};
    // Class decode
    always_comb begin
        is_ind = 1'b0;
        is_pgm = 1'b0;
        is_mem_rd = 1'b0;
        is_mem_wr = 1'b0;
        case (op_code)
            OP_INDIRECT_READ: begin
                is_ind = 1'b1;
                is_mem_rd = 1'b1;
            end
            OP_INDIRECT_WRITE: begin
                is_ind = 1'b1;
                is_mem_wr = 1'b1;
            end
            OP_DISPLACED_READ, OP_DIRECT_MEMORY_READ, OP_POP: is_mem_rd = 1'b1;
            OP_DISPLACED_WRITE, OP_DIRECT_MEMORY_WRITE, OP_PUSH: is_mem_wr = 1'b1;
            OP_PROGRAM_MEMORY_READ, OP_PROGRAM_MEMORY_READ_R0: is_pgm = 1'b1;
            default: is_ind = 1'b0;
        endcase
    end

    // Pointer pair select, program reads always use the top pair
    always_comb begin
        if (is_pgm) begin
            ptr_idx = `PTR_Z_LO; // RL15
        end else begin
            case (op_ptr)
                PTR_X: ptr_idx = `PTR_X_LO; // RL21
                PTR_Y: ptr_idx = `PTR_Y_LO; // RL21
                PTR_Z: ptr_idx = `PTR_Z_LO; // RL21
                default: ptr_idx = `PTR_Z_LO;
            endcase
        end
    end

    // Pair value, low byte in the even register
    assign ptr_val = {gpr_reg[ptr_idx | 5'h01], gpr_reg[ptr_idx]}; // RL21
    // Pointer adjust value, down only for pre-decrement
    assign ptr_new = (op_mode == AM_PRE_DEC) ? ptr_val - 16'h0001 : ptr_val + 16'h0001; // RL8
    // Pointer written back only for adjusting forms
    assign ptr_upd = is_ind ? ((op_mode == AM_POST_INC) || (op_mode == AM_PRE_DEC))
        : ((op_code == OP_PROGRAM_MEMORY_READ) && (op_mode == AM_POST_INC)); // RL15

    // Effective data address
    always_comb begin
        case (op_code)
            OP_INDIRECT_READ, OP_INDIRECT_WRITE: begin
                if (op_mode == AM_PRE_DEC) begin
                    eff_addr = ptr_new; // RL8 RL11
                end else begin
                    eff_addr = ptr_val; // RL7 RL10
                end
            end
            OP_DISPLACED_READ, OP_DISPLACED_WRITE: begin
                eff_addr = ptr_val + {10'h000, op_disp}; // RL9 RL12
            end
            OP_DIRECT_MEMORY_READ, OP_DIRECT_MEMORY_WRITE: eff_addr = op_addr; // RL13 RL14
            OP_PUSH: eff_addr = sp_reg; // RL22
            OP_POP: eff_addr = sp_reg + 16'h0001; // RL22
            default: eff_addr = ptr_val;
        endcase
    end

    // Sequencer: memory ops hold one extra cycle, program reads two
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept && (is_mem_rd || is_mem_wr)) begin
                        state_reg <= ST_MEM; // RL7 RL13 RL16
                    end else if (accept && is_pgm) begin
                        state_reg <= ST_PGM1; // RL15
                    end
                end
                ST_MEM: state_reg <= ST_IDLE;
                ST_PGM1: state_reg <= ST_PGM2;
                ST_PGM2: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Load target capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dst_reg <= 5'h00;
            load_pend_reg <= 1'b0;
            byte_sel_reg <= 1'b0;
        end else if (accept) begin
            // Operand-less program read lands in register 0
            dst_reg <= (op_code == OP_PROGRAM_MEMORY_READ_R0) ? 5'h00 : op_rd; // RL15
            load_pend_reg <= is_mem_rd;
            byte_sel_reg <= ptr_val[0];
        end
    end

    // Data memory drive, strobes last one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dmem_addr <= 16'h0000;
            dmem_wdata <= 8'h00;
            dmem_we <= 1'b0;
            dmem_re <= 1'b0;
        end else begin
            dmem_we <= accept && is_mem_wr; // RL10 RL14 RL16
            dmem_re <= accept && is_mem_rd; // RL7 RL13 RL17
            if (accept && (is_mem_rd || is_mem_wr)) begin
                dmem_addr <= eff_addr;
                dmem_wdata <= rr_val;
            end
        end
    end

    // Program memory drive, word address from the top pair
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pmem_addr <= 15'h0000;
            pmem_re <= 1'b0;
        end else begin
            pmem_re <= accept && is_pgm;
            if (accept && is_pgm) begin
                pmem_addr <= ptr_val[15:1]; // RL15
            end
        end
    end

    // General registers: port write, then op results override
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `GPR_COUNT; i++) begin
                gpr_reg[i] <= `GPR_RESET;
            end
        end else begin
            // Register port write
            if (reg_we && !reg_addr[5]) begin
                gpr_reg[reg_addr[4:0]] <= reg_wdata;
            end
            if (accept) begin
                case (op_code)
                    OP_ROTATE_RIGHT_VIA_CARRY: gpr_reg[op_rd] <= ror_val; // RL1
                    OP_TRANSFER_FLAG_TO_REG_BIT: begin
                        gpr_reg[op_rd][op_bit] <= flags_reg[`FLAG_T]; // RL3
                    end
                    default: ;
                endcase
                // Pointer adjust at issue
                if (ptr_upd) begin
                    gpr_reg[ptr_idx] <= ptr_new[7:0]; // RL7 RL8 RL10 RL11
                    gpr_reg[ptr_idx | 5'h01] <= ptr_new[15:8];
                end
            end
            // Data load completes in the second cycle
            if (state_reg == ST_MEM && load_pend_reg) begin
                gpr_reg[dst_reg] <= dmem_rdata; // RL7 RL9 RL13 RL17
            end
            // Program byte completes in the third cycle
            if (state_reg == ST_PGM2) begin
                gpr_reg[dst_reg] <= byte_sel_reg ? pmem_rdata[15:8] : pmem_rdata[7:0]; // RL15
            end
        end
    end

    // Status flags: memory, stack and control ops never touch them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_reg <= `FLAGS_RESET;
        end else begin
            // Register port write
            if (reg_we && reg_addr == `BUS_FLAGS) begin
                flags_reg <= reg_wdata;
            end
            if (accept) begin
                case (op_code)
                    OP_ROTATE_RIGHT_VIA_CARRY: begin
                        flags_reg[`FLAG_C] <= rd_val[0]; // RL1
                        flags_reg[`FLAG_N] <= ror_val[7]; // RL1
                        flags_reg[`FLAG_Z] <= (ror_val == 8'h00); // RL1
                        flags_reg[`FLAG_V] <= ror_val[7] ^ rd_val[0]; // RL1
                    end
                    OP_REG_BIT_TO_TRANSFER_FLAG: flags_reg[`FLAG_T] <= rr_val[op_bit]; // RL2
                    OP_FLAG_FORCE_ONE: flags_reg[op_bit] <= 1'b1;
                    OP_FLAG_FORCE_ZERO: flags_reg[op_bit] <= 1'b0;
                    OP_OVERFLOW_FLAG_FORCE_ONE: flags_reg[`FLAG_V] <= 1'b1; // RL4
                    OP_OVERFLOW_FLAG_FORCE_ZERO: flags_reg[`FLAG_V] <= 1'b0; // RL4
                    OP_HALF_CARRY_FORCE_ONE: flags_reg[`FLAG_H] <= 1'b1; // RL5
                    OP_HALF_CARRY_FORCE_ZERO: flags_reg[`FLAG_H] <= 1'b0; // RL5
                    OP_SIGNED_FLAG_FORCE_ONE: flags_reg[`FLAG_S] <= 1'b1; // RL6
                    OP_SIGNED_FLAG_FORCE_ZERO: flags_reg[`FLAG_S] <= 1'b0; // RL6
                    default: ;
                endcase
            end
        end
    end

    // Stack pointer, grows downward
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_reg <= `SP_RESET;
        end else begin
            // Register port write of either byte
            if (reg_we && reg_addr == `BUS_SP_LO) begin
                sp_reg[7:0] <= reg_wdata;
            end
            if (reg_we && reg_addr == `BUS_SP_HI) begin
                sp_reg[15:8] <= reg_wdata;
            end
            if (accept && op_code == OP_PUSH) begin
                sp_reg <= sp_reg - 16'h0001; // RL22
            end else if (accept && op_code == OP_POP) begin
                sp_reg <= sp_reg + 16'h0001; // RL22
            end
        end
    end

    // One-cycle pulses to sleep, watchdog and debug logic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_req <= 1'b0;
            wdt_restart <= 1'b0;
            debug_break <= 1'b0;
        end else begin
            sleep_req <= accept && op_code == OP_SLEEP; // RL19
            wdt_restart <= accept && op_code == OP_WATCHDOG_RESTART; // RL20
            debug_break <= accept && op_code == OP_BREAK; // RL18
        end
    end

    // Register port read, data valid one cycle after strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (!reg_re) begin
            reg_rdata <= 8'h00;
        end else if (!reg_addr[5]) begin
            reg_rdata <= gpr_reg[reg_addr[4:0]];
        end else begin
            case (reg_addr)
                `BUS_SP_LO: reg_rdata <= sp_reg[7:0];
                `BUS_SP_HI: reg_rdata <= sp_reg[15:8];
                `BUS_FLAGS: reg_rdata <= flags_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Rotate result and carry out
    a_ror_result: assert property ( // RL1
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_ROTATE_RIGHT_VIA_CARRY && !reg_we)
        |=> (gpr_reg[$past(op_rd)] == $past(ror_val))
            && (flags_reg[`FLAG_C] == $past(rd_val[0]))
    ) else $error("rotate result or carry wrong");
    // Bit into transfer flag, rest kept
    a_bit_to_flag: assert property ( // RL2
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_REG_BIT_TO_TRANSFER_FLAG && !reg_we)
        |=> (flags_reg[`FLAG_T] == $past(rr_val[op_bit]))
            && ((flags_reg & 8'hBF) == ($past(flags_reg) & 8'hBF))
    ) else $error("transfer flag copy wrong");
    // Flag into bit leaves flags alone
    a_flag_to_bit: assert property ( // RL3
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_TRANSFER_FLAG_TO_REG_BIT && !reg_we)
        |=> $stable(flags_reg)
    ) else $error("flags changed on bit load");
    // Overflow force touches one flag
    a_ovf_force: assert property ( // RL4
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_OVERFLOW_FLAG_FORCE_ONE && !reg_we)
        |=> flags_reg == ($past(flags_reg) | 8'h08)
    ) else $error("overflow force wrong");
    // Half-carry clear touches one flag
    a_half_clear: assert property ( // RL5
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_HALF_CARRY_FORCE_ZERO && !reg_we)
        |=> flags_reg == ($past(flags_reg) & 8'hDF)
    ) else $error("half-carry clear wrong");
    // Signed force touches one flag
    a_signed_force: assert property ( // RL6
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_SIGNED_FLAG_FORCE_ONE && !reg_we)
        |=> flags_reg == ($past(flags_reg) | 8'h10)
    ) else $error("signed force wrong");
    // Data ops take two cycles
    a_mem_two_cyc: assert property ( // RL7
        @(posedge clk) disable iff (!rst_b)
        (accept && (is_mem_rd || is_mem_wr))
        |=> !op_ready ##1 op_ready
    ) else $error("data op not two cycles");
    // Pre-decrement addresses the new pointer
    a_predec_addr: assert property ( // RL8
        @(posedge clk) disable iff (!rst_b)
        (accept && is_ind && op_mode == AM_PRE_DEC)
        |=> dmem_addr == $past(ptr_val) - 16'h0001
    ) else $error("pre-decrement address wrong");
    // Program read takes three cycles
    a_pgm_three_cyc: assert property ( // RL15
        @(posedge clk) disable iff (!rst_b)
        (accept && is_pgm) |=> !op_ready [*2] ##1 op_ready
    ) else $error("program read not three cycles");
    // Push writes at old pointer, then decrements
    a_push_stack: assert property ( // RL16
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_PUSH && !reg_we)
        |=> dmem_we && (dmem_addr == $past(sp_reg))
            && (sp_reg == $past(sp_reg) - 16'h0001)
    ) else $error("push stack update wrong");
    // Sleep pulse one cycle long, again only for a new sleep
    a_ctrl_pulse: assert property ( // RL19
        @(posedge clk) disable iff (!rst_b)
        (accept && op_code == OP_SLEEP)
        |=> sleep_req ##1 (sleep_req == $past(accept && op_code == OP_SLEEP))
    ) else $error("sleep pulse wrong");

endmodule // cpu_bitop_transfer_exec

// ---- exec_consts.svh ----
// Contract
// RL1 - Rotate right through carry, flags, one cycle
// RL2 - Copy chosen register bit into transfer flag
// RL3 - Copy transfer flag into chosen register bit
// RL4 - Force overflow flag one or zero alone
// RL5 - Force half-carry flag one or zero alone
// RL6 - Force signed flag one or zero alone
// RL7 - Indirect read then pointer plus one, two cycles
// RL8 - Pointer minus one then indirect read, two cycles
// RL9 - Read at upper pointer plus displacement, two cycles
// RL10 - Indirect write then pointer plus one
// RL11 - Pointer minus one then indirect write
// RL12 - Write at upper pointer plus displacement
// RL13 - Direct address read, two cycles, no flags
// RL14 - Direct address write, two cycles, no flags
// RL15 - Program memory byte via top pointer, three cycles
// RL16 - Push source register, two cycles, no flags
// RL17 - Pop into destination, two cycles, no flags
// RL18 - Break only signals the debug system
// RL19 - Sleep request in one cycle, no flags
// RL20 - Watchdog restart in one cycle, no flags
// RL21 - Pointer pairs are registers 26 to 31
// RL22 - Stack post-decrements on push, pre-increments on pop
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// Status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// Low register of each pointer pair
`define PTR_X_LO 5'h1A
`define PTR_Y_LO 5'h1C
`define PTR_Z_LO 5'h1E

// Register port map above the general registers
`define BUS_SP_LO 6'h3D
`define BUS_SP_HI 6'h3E
`define BUS_FLAGS 6'h3F

// Reset values
`define SP_RESET 16'h00FF
`define FLAGS_RESET 8'h00
`define GPR_RESET 8'h00
`define GPR_COUNT 32

`endif

// ---- exec_pkg.sv ----
package exec_pkg;

    // Operation codes on the issue port
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ROTATE_RIGHT_VIA_CARRY = 5'h01,
        OP_REG_BIT_TO_TRANSFER_FLAG = 5'h02,
        OP_TRANSFER_FLAG_TO_REG_BIT = 5'h03,
        OP_FLAG_FORCE_ONE = 5'h04,
        OP_FLAG_FORCE_ZERO = 5'h05,
        OP_OVERFLOW_FLAG_FORCE_ONE = 5'h06,
        OP_OVERFLOW_FLAG_FORCE_ZERO = 5'h07,
        OP_HALF_CARRY_FORCE_ONE = 5'h08,
        OP_HALF_CARRY_FORCE_ZERO = 5'h09,
        OP_SIGNED_FLAG_FORCE_ONE = 5'h0A,
        OP_SIGNED_FLAG_FORCE_ZERO = 5'h0B,
        OP_INDIRECT_READ = 5'h0C,
        OP_INDIRECT_WRITE = 5'h0D,
        OP_DISPLACED_READ = 5'h0E,
        OP_DISPLACED_WRITE = 5'h0F,
        OP_DIRECT_MEMORY_READ = 5'h10,
        OP_DIRECT_MEMORY_WRITE = 5'h11,
        OP_PROGRAM_MEMORY_READ = 5'h12,
        OP_PROGRAM_MEMORY_READ_R0 = 5'h13,
        OP_PUSH = 5'h14,
        OP_POP = 5'h15,
        OP_SLEEP = 5'h16,
        OP_WATCHDOG_RESTART = 5'h17,
        OP_BREAK = 5'h18
    } op_e;

    // Pointer adjust mode
    typedef enum logic [1:0] {
        AM_PLAIN = 2'h0,
        AM_POST_INC = 2'h1,
        AM_PRE_DEC = 2'h2
    } addr_mode_e;

    // Pointer pair select
    typedef enum logic [1:0] {
        PTR_X = 2'h0,
        PTR_Y = 2'h1,
        PTR_Z = 2'h2
    } ptr_e;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_MEM = 2'h1,
        ST_PGM1 = 2'h2,
        ST_PGM2 = 2'h3
    } state_e;

endpackage

// ---- mem_model.sv ----
`timescale 1ns/100ps
// Data and program memory on the far side of the block
module mem_model (
    // Clock
    input wire logic clk,
    // Data memory
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    input wire logic dmem_re,
    output logic [7:0] dmem_rdata,
    // Program memory
    input wire logic [14:0] pmem_addr,
    input wire logic pmem_re,
    output logic [15:0] pmem_rdata
);
    logic [7:0] mem [256]; // Bytes by low address bits
    logic hold = 1'b0; // Word still wanted one more cycle
    logic [15:0] w; // Word pattern at the current address
    // Known contents
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    // Writes land on the strobe edge
    always @(posedge clk) begin
        if (dmem_we) mem[dmem_addr[7:0]] <= dmem_wdata;
        hold <= pmem_re;
    end
    assign w = {pmem_addr[7:0] ^ 8'hC3, pmem_addr[7:0]};
    // Not asked for: show the inverse, never a stale value
    assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];
    assign pmem_rdata = (pmem_re || hold) ? w : ~w;
endmodule // mem_model

// ---- tb.sv ----
`timescale 1ns/100ps
`include "exec_consts.svh"
module tb;
    import exec_pkg::*;
    // Design ports
    logic clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, op_ready;
    op_e op_code = OP_NOP;
    logic [4:0] op_rd = 5'h00, op_rr = 5'h00;
    logic [2:0] op_bit = 3'h0;
    addr_mode_e op_mode = AM_PLAIN;
    ptr_e op_ptr = PTR_X;
    logic [5:0] op_disp = 6'h00, reg_addr = 6'h00;
    logic [15:0] op_addr = 16'h0000, dmem_addr, pmem_rdata;
    logic [7:0] dmem_wdata, dmem_rdata, reg_wdata = 8'h00, reg_rdata, status_flags;
    logic dmem_we, dmem_re, pmem_re, sleep_req, wdt_restart, debug_break;
    logic reg_we = 1'b0, reg_re = 1'b0;
    logic [14:0] pmem_addr;
    int failures = 0, checked = 0, sc = 0, wc = 0, bc = 0;
    // Flag force sequence and the flags after each
    op_e fo [6] = '{OP_OVERFLOW_FLAG_FORCE_ONE, OP_HALF_CARRY_FORCE_ONE,
        OP_SIGNED_FLAG_FORCE_ONE, OP_OVERFLOW_FLAG_FORCE_ZERO,
        OP_HALF_CARRY_FORCE_ZERO, OP_SIGNED_FLAG_FORCE_ZERO};
    logic [7:0] fe [6] = '{8'h4D, 8'h6D, 8'h7D, 8'h75, 8'h55, 8'h45};
    // Pointer start values, registers 26 to 31
    logic [7:0] pv [6] = '{8'hFF, 8'h00, 8'h20, 8'h00, 8'h30, 8'h00};
    // Registers after the loads and their values
    logic [5:0] lr [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h1A, 6'h1B, 6'h1C, 6'h1E};
    logic [7:0] lv [8] = '{8'hA5, 8'h45, 8'h6F, 8'h1A, 8'h00, 8'h01, 8'h1F, 8'h30};
    // Store targets read back and the bytes expected
    logic [15:0] ra [4] = '{16'h0100, 16'h001E, 16'h005D, 16'h0060};
    logic [7:0] rv [4] = '{8'h80, 8'hF4, 8'h10, 8'h00};

    cpu_bitop_transfer_exec cpu_bitop_transfer_exec_i (.*);
    mem_model mem_model_i (.*);

    // Clock
    always #50 clk = ~clk;
    // Count control pulses
    always @(posedge clk) begin
        if (sleep_req === 1'b1) sc++;
        if (wdt_restart === 1'b1) wc++;
        if (debug_break === 1'b1) bc++;
    end

    // Compare one byte
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    // Register port write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    // Register port read, data in the following cycle
    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // Issue one operation and measure the cycles the issue port stays busy
    task automatic op(input op_e c, input logic [7:0] cyc, input logic [4:0] r,
        input logic [5:0] q, input addr_mode_e m = AM_PLAIN, input ptr_e p = PTR_X,
        input logic [15:0] a = 16'h0000);
        int n;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_rd <= r;
        op_rr <= r;
        op_bit <= q[2:0];
        op_disp <= q;
        op_mode <= m;
        op_ptr <= p;
        op_addr <= a;
        @(posedge clk);
        op_valid <= 1'b0;
        n = 0;
        #1;
        while (op_ready !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("busy cycles", cyc, 8'(n));
    endtask

    // Verdict
    task automatic final_report();
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog
    initial begin
        #400000;
        failures++;
        final_report();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd(`BUS_FLAGS, `FLAGS_RESET, "flags");
        rd(`BUS_SP_LO, 8'hFF, "sp_lo");
        rd(`BUS_SP_HI, 8'h00, "sp_hi");
        wr(6'h20, 8'hA5);
        rd(6'h20, 8'h00, "unmapped");
        // Rotate to zero, then to a negative value with carry in
        wr(6'h06, 8'h01);
        wr(6'h05, 8'h01);
        op(OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 5'h06, 6'h00);
        chk("flags", 8'h0B, status_flags);
        op(OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 5'h05, 6'h00);
        chk("flags", 8'h05, status_flags);
        rd(6'h06, 8'h00, "r6");
        rd(6'h05, 8'h80, "r5");
        // Transfer bit in and out
        wr(6'h07, 8'h10);
        wr(6'h08, 8'hF0);
        op(OP_REG_BIT_TO_TRANSFER_FLAG, 8'h00, 5'h07, 6'h04);
        chk("flags", 8'h45, status_flags);
        op(OP_TRANSFER_FLAG_TO_REG_BIT, 8'h00, 5'h08, 6'h02);
        chk("flags", 8'h45, status_flags);
        rd(6'h08, 8'hF4, "r8");
        // Each dedicated flag force in turn
        for (int i = 0; i < 6; i++) begin
            op(fo[i], 8'h00, 5'h00, 6'h00);
            chk("flags", fe[i], status_flags);
        end
        // Generic force on the overflow position
        op(OP_FLAG_FORCE_ONE, 8'h00, 5'h00, 6'h03);
        chk("flags", 8'h4D, status_flags);
        op(OP_FLAG_FORCE_ZERO, 8'h00, 5'h00, 6'h03);
        chk("flags", 8'h45, status_flags);
        // Loads; X starts at a page edge
        for (int i = 0; i < 6; i++) wr(6'h1A + 6'(i), pv[i]);
        op(OP_INDIRECT_READ, 8'h01, 5'h01, 6'h00, AM_POST_INC, PTR_X);
        op(OP_INDIRECT_READ, 8'h01, 5'h02, 6'h00, AM_PRE_DEC, PTR_Y);
        op(OP_DISPLACED_READ, 8'h01, 5'h03, 6'h05, AM_PLAIN, PTR_Z);
        op(OP_DIRECT_MEMORY_READ, 8'h01, 5'h04, 6'h00, AM_PLAIN, PTR_X, 16'h0040);
        for (int i = 0; i < 8; i++) rd(lr[i], lv[i], "load");
        chk("flags", 8'h45, status_flags);
        // Stores, then read back through direct loads
        op(OP_INDIRECT_WRITE, 8'h01, 5'h05, 6'h00, AM_POST_INC, PTR_X);
        op(OP_INDIRECT_WRITE, 8'h01, 5'h08, 6'h00, AM_PRE_DEC, PTR_Y);
        op(OP_DISPLACED_WRITE, 8'h01, 5'h07, 6'h3F, AM_PLAIN, PTR_Y);
        op(OP_DIRECT_MEMORY_WRITE, 8'h01, 5'h06, 6'h00, AM_PLAIN, PTR_X, 16'h0060);
        rd(6'h1A, 8'h01, "x_lo");
        rd(6'h1C, 8'h1E, "y_lo");
        for (int i = 0; i < 4; i++) begin
            op(OP_DIRECT_MEMORY_READ, 8'h01, 5'h0A + 5'(i), 6'h00, AM_PLAIN, PTR_X, ra[i]);
            rd(6'h0A + 6'(i), rv[i], "readback");
        end
        chk("flags", 8'h45, status_flags);
        // Stack round trip
        op(OP_PUSH, 8'h01, 5'h05, 6'h00);
        rd(`BUS_SP_LO, 8'hFE, "sp_lo");
        op(OP_POP, 8'h01, 5'h09, 6'h00);
        rd(`BUS_SP_LO, 8'hFF, "sp_lo");
        rd(6'h09, 8'h80, "r9");
        chk("flags", 8'h45, status_flags);
        // Program memory, odd then even byte
        wr(6'h1E, 8'h31);
        op(OP_PROGRAM_MEMORY_READ, 8'h02, 5'h0E, 6'h00, AM_POST_INC, PTR_Z);
        rd(6'h0E, 8'hDB, "r14");
        rd(6'h1E, 8'h32, "z_lo");
        op(OP_PROGRAM_MEMORY_READ_R0, 8'h02, 5'h00, 6'h00);
        rd(6'h00, 8'h19, "r0");
        // Control pulses back to back
        op(OP_SLEEP, 8'h00, 5'h00, 6'h00);
        op(OP_WATCHDOG_RESTART, 8'h00, 5'h00, 6'h00);
        op(OP_BREAK, 8'h00, 5'h00, 6'h00);
        repeat (2) @(posedge clk);
        #1;
        chk("sleep pulses", 8'h01, 8'(sc));
        chk("wdt pulses", 8'h01, 8'(wc));
        chk("break pulses", 8'h01, 8'(bc));
        chk("flags", 8'h45, status_flags);
        final_report();
    end
endmodule // tb
